// [core/alp_param_reg.sv]
`include "alp_regs.svh"
module alp_param_reg (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_selftimed_en,
   output logic [7:0] o_reg_rdata,
   output alp_pkg::cfg_t o_active
);
   alp_pkg::reg_state_t q, d;

   // the active copy follows the register only while periodic mode is off,
   // so a running periodic sequence never sees a half-changed setting
   always_comb begin
      d = q;
      if (i_reg_wr && i_reg_addr == `ALP_PARAM_ADDR) begin
         d.param = alp_pkg::cfg_t'(i_reg_wdata);
      end
      if (!i_selftimed_en) begin
         d.active = d.param;
      end
      d.rdata = (i_reg_addr == `ALP_PARAM_ADDR) ? 8'(d.param) : 8'h00;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q.param <= alp_pkg::cfg_t'(`ALP_PARAM_RESET);
         q.active <= alp_pkg::cfg_t'(`ALP_PARAM_RESET);
         q.rdata <= 8'h00;
      end else begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.rdata;
   assign o_active = q.active;

   AST_CONT_RESET: assert property (@(posedge i_clk) $rose(i_nrst) |->
      q.param[`ALP_CONT_BIT] == `ALP_CONT_RESET) else $error("continuous bit not clear at reset");
   AST_OFFS_RESET: assert property (@(posedge i_clk) $rose(i_nrst) |->
      q.param[`ALP_OFFS_BIT] == `ALP_OFFS_RESET) else $error("offset enable not set at reset");
   AST_AVG_RESET: assert property (@(posedge i_clk) $rose(i_nrst) |->
      q.param[`ALP_AVG_LSB +: 3] == `ALP_AVG_RESET) else $error("averaging not 101 at reset");
   AST_RATE_RESET: assert property (@(posedge i_clk) $rose(i_nrst) |->
      q.param[`ALP_RATE_LSB +: 3] == `ALP_RATE_RESET) else $error("rate not 000 at reset");
   AST_HOLD_PERIODIC: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_selftimed_en && $past(i_selftimed_en) |-> $stable(q.active))
      else $error("active setting changed during periodic mode");
   AST_WRITE_TAKES: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_reg_wr && i_reg_addr == `ALP_PARAM_ADDR && !i_selftimed_en ##1 !i_selftimed_en
      |-> q.active == $past(i_reg_wdata)) else $error("write not taken while periodic off");
endmodule

// [core/alp_pkg.sv]
package alp_pkg;
   // parameter register layout, msb first as the register holds it
   typedef struct packed {
      logic cont;
      logic [2:0] rate;
      logic offs_en;
      logic [2:0] avg;
   } cfg_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_OFFSET = 2'b01,
      SEQ_SAMPLE = 2'b10,
      SEQ_DONE = 2'b11
   } seq_state_t;

   // request towards the converter
   typedef struct packed {
      logic req;
      logic offset;
      logic cont;
   } conv_req_t;

   typedef struct packed {
      cfg_t param;
      cfg_t active;
      logic [7:0] rdata;
   } reg_state_t;

   typedef struct packed {
      seq_state_t st;
      logic [7:0] cnt;
      logic [22:0] sum;
      logic [15:0] offs;
      logic [15:0] result;
      logic valid;
      logic busy;
      conv_req_t conv;
      cfg_t cfg;
   } seq_t;
endpackage

// [core/alp_regs.svh]
`ifndef ALP_REGS_SVH
`define ALP_REGS_SVH
// Notes on behaviour
// - bit 7 enables continuous ambient conversion; it comes up cleared
// - bit 3 enables automatic offset compensation; it comes up set
// - with compensation on, offset is measured first and subtracted from the reading
// - bits 2..0 pick two to that power single conversions per cycle, 1 to 128
// - reported result is the arithmetic mean of the cycle's conversions
// - averaging field resets to 101, thirty-two conversions per cycle
// - a write during periodic mode takes effect only after the mode is cycled

// register offset on the register port
`define ALP_PARAM_ADDR 8'h84
// reset value: continuous off, rate 000, offset on, averaging 101
`define ALP_PARAM_RESET 8'h0D
// field positions
`define ALP_CONT_BIT 7
`define ALP_RATE_LSB 4
`define ALP_OFFS_BIT 3
`define ALP_AVG_LSB 0
// reset values of single fields
`define ALP_CONT_RESET 1'h0
`define ALP_RATE_RESET 3'h0
`define ALP_OFFS_RESET 1'h1
`define ALP_AVG_RESET 3'h5
`endif

// [core/ambient_light_param_control.sv]
`include "alp_regs.svh"
module ambient_light_param_control (
   input wire logic i_clk,
   input wire logic i_nrst,
   // register port from the serial front end
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // command state from the command register
   input wire logic i_selftimed_en,
   input wire logic i_ambient_single_shot,
   // start of one measurement cycle from the rate timer or on-demand logic
   input wire logic i_meas_start,
   // converter handshake
   output logic o_conv_req,
   output logic o_conv_offset,
   output logic o_conv_cont,
   input wire logic i_conv_done,
   input wire logic [15:0] i_conv_data,
   // results and status
   output logic [15:0] o_als_result,
   output logic o_als_valid,
   output logic o_busy,
   output logic [2:0] o_als_rate
);
   alp_pkg::cfg_t active;
   alp_pkg::seq_t q, d;
   logic [15:0] mean;
   logic [7:0] target;

   alp_param_reg u_param (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_reg_wr(i_reg_wr),
      .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata),
      .i_selftimed_en(i_selftimed_en),
      .o_reg_rdata(o_reg_rdata),
      .o_active(active)
   );

   // number of single conversions in this cycle, two to the field value
   assign target = 8'h01 << q.cfg.avg;
   // the mean is the sum shifted by the same exponent, exact for powers of two
   assign mean = 16'(q.sum >> q.cfg.avg);

   // measurement sequencer: optional offset conversion, then the sample burst
   // the configuration is copied at start and held for the whole burst, so a
   // register write in mid-burst only shows from the next cycle on
   // the sum is wide enough for 128 full-scale samples, so it needs no overflow guard
   // limitation: a start while busy is dropped, not queued
   always_comb begin
      d = q;
      d.valid = 1'b0;
      case (q.st)
         alp_pkg::SEQ_IDLE: begin
            // a single-shot request also starts a cycle; periodic starts arrive
            // on i_meas_start from the rate timer
            if (i_meas_start || i_ambient_single_shot) begin
               d.cfg = active; // settings frozen for the whole cycle
               d.cnt = 8'h00;
               d.sum = 23'h000000;
               d.offs = 16'h0000;
               d.busy = 1'b1;
               d.conv.req = 1'b1;
               d.conv.cont = active.cont;
               if (active.offs_en) begin
                  d.st = alp_pkg::SEQ_OFFSET;
                  d.conv.offset = 1'b1;
               end else begin
                  d.st = alp_pkg::SEQ_SAMPLE;
                  d.conv.offset = 1'b0;
               end
            end
         end
         alp_pkg::SEQ_OFFSET: begin
            // offset is taken right before the light samples
            if (i_conv_done) begin
               d.offs = i_conv_data;
               d.conv.offset = 1'b0;
               d.st = alp_pkg::SEQ_SAMPLE;
            end
         end
         alp_pkg::SEQ_SAMPLE: begin
            if (i_conv_done) begin
               d.sum = q.sum + 23'(i_conv_data);
               d.cnt = q.cnt + 8'h01;
               if (q.cnt + 8'h01 == target) begin
                  d.conv.req = 1'b0;
                  d.conv.cont = 1'b0;
                  d.st = alp_pkg::SEQ_DONE;
               end
            end
         end
         alp_pkg::SEQ_DONE: begin
            // subtraction saturates at zero: dark readings never wrap
            if (q.cfg.offs_en) begin
               d.result = (mean > q.offs) ? mean - q.offs : 16'h0000;
            end else begin
               d.result = mean;
            end
            d.valid = 1'b1;
            d.busy = 1'b0;
            d.st = alp_pkg::SEQ_IDLE;
         end
         default: begin
            d.st = alp_pkg::SEQ_IDLE;
            d.busy = 1'b0;
            d.conv = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q.st <= alp_pkg::SEQ_IDLE;
         q.cnt <= 8'h00;
         q.sum <= 23'h000000;
         q.offs <= 16'h0000;
         q.result <= 16'h0000;
         q.valid <= 1'b0;
         q.busy <= 1'b0;
         q.conv <= '0;
         q.cfg <= alp_pkg::cfg_t'(`ALP_PARAM_RESET);
      end else begin
         q <= d;
      end
   end

   // outputs come straight from state flops here and in the register block
   assign o_conv_req = q.conv.req;
   assign o_conv_offset = q.conv.offset;
   assign o_conv_cont = q.conv.cont;
   assign o_als_result = q.result;
   assign o_als_valid = q.valid;
   assign o_busy = q.busy;
   assign o_als_rate = active.rate;

   // offset conversion goes out first when compensation is on
   AST_OFFSET_FIRST: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_IDLE && (i_meas_start || i_ambient_single_shot) && active.offs_en
      |=> o_conv_req && o_conv_offset && q.st == alp_pkg::SEQ_OFFSET)
      else $error("offset conversion not requested first");

   // without compensation the first request is already a light sample
   AST_NO_OFFSET: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_IDLE && (i_meas_start || i_ambient_single_shot) && !active.offs_en
      |=> o_conv_req && !o_conv_offset) else $error("offset taken while disabled");

   // the burst length matches the averaging field
   AST_SAMPLE_COUNT: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_als_valid |-> q.cnt == (8'h01 << q.cfg.avg)) else $error("wrong conversion count");

   // one conversion without offset is passed through unchanged
   AST_MEAN_SINGLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_SAMPLE && i_conv_done && q.cfg.avg == 3'h0 && !q.cfg.offs_en
      |-> ##2 o_als_valid && o_als_result == $past(i_conv_data, 2))
      else $error("single conversion result not passed through");

   // continuous flag copies bit 7 for starts of either kind
   AST_CONT_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_IDLE && (i_meas_start || i_ambient_single_shot)
      |=> o_conv_cont == $past(active.cont))
      else $error("continuous conversion not following bit 7");

   // the request stands until the last sample is accepted; 1000 cycles
   // cover 129 conversions even at the slowest converter pace used here
   AST_REQ_UNTIL_DONE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(o_busy) |-> o_conv_req throughout
      (##[0:1000] (q.st == alp_pkg::SEQ_SAMPLE && i_conv_done && q.cnt + 8'h01 == target)))
      else $error("request dropped before burst finished");

   // offset value is latched and the request switches to light samples
   AST_OFFSET_LATCH: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_OFFSET && i_conv_done
      |=> q.offs == $past(i_conv_data) && !o_conv_offset && q.st == alp_pkg::SEQ_SAMPLE)
      else $error("offset value not latched");

   // no offset request once light samples are being taken
   AST_OFFSET_NOT_IN_BURST: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_SAMPLE |-> !o_conv_offset)
      else $error("offset requested during sample burst");

   // a burst starts from a cleared sum and count
   AST_SUM_CLEARED: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_SAMPLE && $past(q.st) != alp_pkg::SEQ_SAMPLE
      |-> q.sum == 23'h000000 && q.cnt == 8'h00)
      else $error("burst started with stale sum");

   // count never reaches the target while the burst is still running
   AST_COUNT_BELOW: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_SAMPLE |-> q.cnt < target)
      else $error("sample count ran past the averaging target");

   // an average below the offset reports zero rather than wrapping
   AST_RESULT_FLOOR: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_DONE && q.cfg.offs_en && mean <= q.offs
      |=> o_als_result == 16'h0000)
      else $error("offset subtraction wrapped below zero");

   // the result changes only on leaving the done state
   AST_RESULT_HOLDS: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st != alp_pkg::SEQ_DONE |=> $stable(o_als_result))
      else $error("result changed outside the done state");

   // the done state lasts one cycle and flags the new result
   AST_DONE_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_DONE |=> q.st == alp_pkg::SEQ_IDLE && o_als_valid)
      else $error("done state not left after one cycle");

   // the valid flag is a single-cycle pulse
   AST_VALID_PULSE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_als_valid |=> !o_als_valid)
      else $error("valid held longer than one cycle");

   // busy is gone by the time the result is flagged
   AST_BUSY_CLEARS: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_als_valid |-> !o_busy)
      else $error("busy still set with a new result");

   // settings stay frozen for the whole burst
   AST_CFG_FROZEN: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_busy && $past(o_busy) |-> $stable(q.cfg))
      else $error("settings changed during a burst");

   // converter lines rest while idle
   AST_IDLE_QUIET: assert property (@(posedge i_clk) disable iff (!i_nrst)
      q.st == alp_pkg::SEQ_IDLE |-> !o_conv_req && !o_conv_offset && !o_conv_cont)
      else $error("converter request while idle");

   // continuous flag only rides on a request of a burst with bit 7 set
   AST_CONT_IN_BURST: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_conv_cont |-> o_conv_req && q.cfg.cont)
      else $error("continuous flag outside a continuous burst");
endmodule

// [verif/conv_model.sv]
// converter on the far side: one conversion after every i_dly + 1 idle cycles for as long as the request is held
module conv_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_req,
   input wire logic i_offset,
   input wire logic [1:0] i_dly,
   input wire logic [15:0] i_offs_val,
   input wire logic [15:0] i_samp_val,
   output logic o_done,
   output logic [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q;
   logic [15:0] k_q;
   // samples ramp by one so that a wrong divisor shows in the mean
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_done <= 1'b0;
         o_data <= 16'h0000;
         wait_q <= 2'h0;
         k_q <= 16'h0000;
      end else begin
         o_done <= 1'b0;
         o_data <= ~o_data; // no stale value between conversions
         if (!i_req) begin
            k_q <= 16'h0000;
         end else if (!o_done && wait_q == i_dly) begin
            o_done <= 1'b1;
            wait_q <= 2'h0;
            o_data <= i_offset ? i_offs_val : i_samp_val + k_q;
            k_q <= i_offset ? k_q : k_q + 16'h0001;
         end else if (!o_done) begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end
endmodule

// [verif/tb_top.sv]
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] cfg; logic [15:0] ov; logic [15:0] sv; logic [15:0] res;} row_t;
   logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, ss = 1'b0, start = 1'b0, st_en = 1'b0;
   logic [7:0] addr = 8'h84, wdata = 8'h00, rdata;
   logic [1:0] dly = 2'h0;
   logic [15:0] offs_v = 16'h0000, samp_v = 16'h0000, cdata, result;
   logic req, offs, cont, done, valid, busy;
   logic [2:0] rate;
   int fail_count = 0, samples_checked = 0, n_samp, n_offs;
   // every averaging code, offset on and off, and a mean below the offset
   row_t rows [9] = '{'{8'h00, 16'h0010, 16'h0100, 16'h0100},
      '{8'h89, 16'h0010, 16'h0100, 16'h00F0}, '{8'h1A, 16'h0010, 16'h0100, 16'h00F1},
      '{8'h23, 16'h0010, 16'h0100, 16'h0103}, '{8'hBC, 16'h0010, 16'h0100, 16'h00F7},
      '{8'h4D, 16'h0010, 16'h0100, 16'h00FF}, '{8'h5E, 16'h0010, 16'h0100, 16'h010F},
      '{8'h67, 16'h0010, 16'h0100, 16'h013F}, '{8'h78, 16'h0200, 16'h0100, 16'h0000}};
   always #12.5 clk = ~clk;
   ambient_light_param_control dut (.i_clk(clk), .i_nrst(nrst), .i_reg_wr(wr),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_selftimed_en(st_en),
      .i_ambient_single_shot(ss), .i_meas_start(start), .o_conv_req(req),
      .o_conv_offset(offs), .o_conv_cont(cont), .i_conv_done(done), .i_conv_data(cdata),
      .o_als_result(result), .o_als_valid(valid), .o_busy(busy), .o_als_rate(rate));
   conv_model conv (.i_clk(clk), .i_nrst(nrst), .i_req(req), .i_offset(offs), .i_dly(dly),
      .i_offs_val(offs_v), .i_samp_val(samp_v), .o_done(done), .o_data(cdata));
   // tally conversions of each kind within one cycle
   always @(posedge clk) begin
      if (done === 1'b1 && offs === 1'b1) n_offs++;
      else if (done === 1'b1) n_samp++;
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #2 wr = 1'b0;
      addr = 8'h84;
   endtask
   // bounded wait; a hang is reported and ends the run
   task automatic wait_valid();
      int i;
      for (i = 0; i < 2000 && valid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (valid !== 1'b1) begin
         fail_count++;
         test_done();
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #2 nrst = 1'b1;
      repeat (2) @(posedge clk);
      #2 `CHK("reset param", 8'h0D, rdata)
      `CHK("reset rate", 3'h0, rate)
      foreach (rows[i]) begin
         dly = 2'(i % 3);
         offs_v = rows[i].ov;
         samp_v = rows[i].sv;
         wr_reg(8'h84, rows[i].cfg);
         `CHK("readback", rows[i].cfg, rdata)
         @(posedge clk);
         n_samp = 0;
         n_offs = 0;
         #2 `CHK("rate", rows[i].cfg[6:4], rate)
         // continuous mode only with on-demand requests, never with periodic mode
         if (rows[i].cfg[7]) ss = 1'b1;
         else start = 1'b1;
         @(posedge clk);
         #1 `CHK("cont", rows[i].cfg[7], cont)
         `CHK("req", 1'b1, req)
         `CHK("offset first", rows[i].cfg[3], offs)
         `CHK("busy", 1'b1, busy)
         #1 ss = 1'b0;
         start = 1'b0;
         wait_valid();
         `CHK("result", rows[i].res, result)
         `CHK("busy done", 1'b0, busy)
         `CHK("samples", 1 << rows[i].cfg[2:0], n_samp)
         `CHK("offsets", int'(rows[i].cfg[3]), n_offs)
      end
      wr_reg(8'h85, 8'hFF);
      `CHK("unmapped read", 8'h00, rdata)
      @(posedge clk);
      #2 `CHK("after unmapped", 8'h78, rdata)
      st_en = 1'b1;
      wr_reg(8'h84, 8'h0D);
      @(posedge clk);
      #2 `CHK("held rate", 3'h7, rate)
      `CHK("held readback", 8'h0D, rdata)
      st_en = 1'b0;
      repeat (2) @(posedge clk);
      #2 `CHK("rate after cycle", 3'h0, rate)
      // reset in mid-burst: outputs clear at once, the register returns to its
      // default and that default then runs a whole cycle
      wr_reg(8'h84, 8'hB2);
      @(posedge clk);
      // continuous mode rides on an on-demand request only
      #2 ss = 1'b1;
      @(posedge clk);
      #2 `CHK("busy before reset", 1'b1, busy)
      `CHK("cont before reset", 1'b1, cont)
      ss = 1'b0;
      nrst = 1'b0;
      #1 `CHK("busy in reset", 1'b0, busy)
      `CHK("req in reset", 1'b0, req)
      `CHK("cont in reset", 1'b0, cont)
      `CHK("rate in reset", 3'h0, rate)
      @(posedge clk);
      #2 nrst = 1'b1;
      n_samp = 0;
      n_offs = 0;
      dly = 2'h0;
      offs_v = 16'h0020;
      samp_v = 16'h0100;
      @(posedge clk);
      #2 `CHK("param after reset", 8'h0D, rdata)
      start = 1'b1;
      @(posedge clk);
      #2 start = 1'b0;
      wait_valid();
      `CHK("result after reset", 16'h00EF, result)
      `CHK("samples after reset", 32, n_samp)
      `CHK("offsets after reset", 1, n_offs)
      test_done();
   end
endmodule
